// file: logic/bgpio_defines.vh
// Register offsets, field masks and reset values of the banked pin block.
`ifndef BGPIO_DEFINES_VH
`define BGPIO_DEFINES_VH

// Global registers.
`define BGPIO_OFS_IDENT 8'h00
`define BGPIO_OFS_BANK_IRQ_ENABLE 8'h08
`define BGPIO_OFS_RISE_TRIGGER_SET 8'h24
`define BGPIO_OFS_RISE_TRIGGER_CLEAR 8'h28
`define BGPIO_OFS_FALL_TRIGGER_SET 8'h2C
`define BGPIO_OFS_FALL_TRIGGER_CLEAR 8'h30

// Base offset of each bank pair register group.
`define BGPIO_OFS_PAIR01 8'h10
`define BGPIO_OFS_PAIR23 8'h38
`define BGPIO_OFS_PAIR45 8'h60
`define BGPIO_OFS_PAIR6 8'h88

// Offsets within a bank pair group.
`define BGPIO_SUB_DIR 8'h00
`define BGPIO_SUB_OUT 8'h04
`define BGPIO_SUB_SET 8'h08
`define BGPIO_SUB_CLR 8'h0C
`define BGPIO_SUB_IN 8'h10

// Field layout.
`define BGPIO_BANK_SIZE 16
`define BGPIO_NUM_BANKS 7
`define BGPIO_NUM_PINS 104
`define BGPIO_NUM_RTC 3
`define BGPIO_RTC_FIRST 104
`define BGPIO_PAIR_W 32
`define BGPIO_PAIR_FULL_MASK 32'hFFFF_FFFF
`define BGPIO_PAIR6_MASK 32'h0000_00FF
`define BGPIO_PAIR6_IN_MASK 32'h0000_07FF
`define BGPIO_BANK_EN_MASK 32'h0000_007F
`define BGPIO_TRIG_MASK 32'h0007_7FFF
`define BGPIO_TRIG_BANK0_LSB 0
`define BGPIO_TRIG_RTC_LSB 16
`define BGPIO_NUM_EVT 15
`define BGPIO_BANK0_EN_BIT 0
`define BGPIO_BANK6_EN_BIT 6

// Reset values.
`define BGPIO_RST_OE 128'h0000_0000_0000_0000_0000_0000_0000_0000
`define BGPIO_RST_OUT 128'h0000_0000_0000_0000_0000_0000_0000_0000
`define BGPIO_RST_TRIG 19'h0_0000
`define BGPIO_RST_BANK_EN 7'h00
`define BGPIO_RST_RDATA 32'h0000_0000
`define BGPIO_RST_SETTLE 2'h0

// Clocks after reset before the edge history holds a real pin sample.
`define BGPIO_SETTLE_CNT 2'h3

`endif

// file: logic/bgpio_top.v
// Banked general-purpose pin block with edge-triggered interrupt and DMA event outputs.
`timescale 1ns/1ns
// Register map, byte offsets on an 8-bit address.
// Offset 0x00 holds the identity word, which is read only.
// Offset 0x08 holds the bank interrupt enable, one bit per bank in bits 6 to 0.
// Offset 0x24 is the rise trigger set, where a one selects a rising edge.
// Offset 0x28 is the rise trigger clear, where a one drops a rising edge.
// Offset 0x2C is the fall trigger set, where a one selects a falling edge.
// Offset 0x30 is the fall trigger clear, where a one drops a falling edge.
// All four trigger offsets read back the selection that they act on.
// Each bank pair group holds five registers from its base.
// Offset +0x00 is the direction, where a one makes the pin an input.
// Offset +0x04 holds the output levels and takes direct writes.
// Offset +0x08 sets output levels where a one is written and reads the levels.
// Offset +0x0C clears output levels where a one is written and reads the levels.
// Offset +0x10 shows the levels seen on the pins and is read only.
// Group bases are 0x10 for banks 0 and 1, 0x38 for banks 2 and 3, 0x60 for
// banks 4 and 5, and 0x88 for bank 6; the even bank sits in the low half.
// In the bank 6 group bits 7 to 0 are pins 96 to 103, and its input
// register adds the three RTC-side pins 104 to 106 in bits 10 to 8.
// Trigger bits 14 to 0 are pins 14 to 0, and bits 18 to 16 are pins 104 to 106.
// Bank enable bit 0 gates the bank zero interrupts and bit 6 the RTC-side
// ones; DMA events are never gated.
// There is no status register: interrupts and events are one-clock pulses.

`include "bgpio_defines.vh"

module bgpio_top #(
  parameter [31:0] IDENT_VALUE = 32'h0001_0000
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire [103:0] pin_in,
  output wire [103:0] pin_out,
  output wire [103:0] pin_oe,
  input wire [2:0] rtc_domain_io_pins,
  output wire [14:0] bank0_irq,
  output wire [2:0] rtc_irq,
  output wire [14:0] bank0_dma_evt
);

  // Bank pair group base offset for pair index 0 to 3.
  function [7:0] pair_base;
    input [1:0] p;
    begin
      case (p)
        2'd0: pair_base = `BGPIO_OFS_PAIR01;
        2'd1: pair_base = `BGPIO_OFS_PAIR23;
        2'd2: pair_base = `BGPIO_OFS_PAIR45;
        default: pair_base = `BGPIO_OFS_PAIR6;
      endcase
    end
  endfunction

  // Bits of a pair that hold real pins; the last pair holds bank six only.
  function [31:0] pair_mask;
    input [1:0] p;
    begin
      if (p == 2'd3) begin
        pair_mask = `BGPIO_PAIR6_MASK;
      end else begin
        pair_mask = `BGPIO_PAIR_FULL_MASK;
      end
    end
  endfunction

  // Bits of a pair that read back through the input register.
  function [31:0] pair_in_mask;
    input [1:0] p;
    begin
      if (p == 2'd3) begin
        pair_in_mask = `BGPIO_PAIR6_IN_MASK;
      end else begin
        pair_in_mask = `BGPIO_PAIR_FULL_MASK;
      end
    end
  endfunction

  // True when an address falls on one register of a bank pair group.
  function pair_hit;
    input [7:0] a;
    input [1:0] grp;
    input [7:0] sub;
    reg [7:0] ofs;
    begin
      ofs = pair_base(grp) + sub;
      pair_hit = (a == ofs);
    end
  endfunction

  // Two-stage synchroniser plus one history stage for edge detection.
  reg [106:0] sync1_q;
  reg [106:0] sync2_q;
  reg [106:0] hist_q;

  // Output enables and output levels, padded to four full pairs.
  reg [127:0] oe_q;
  reg [127:0] out_q;

  // Edge trigger selection: bits 0 to 14 for bank zero, 16 to 18 for RTC pins.
  reg [18:0] rise_trig_q;
  reg [18:0] fall_trig_q;
  reg [6:0] bank_en_q;

  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg [14:0] irq_q;
  reg [2:0] rtc_irq_q;
  reg [14:0] dma_q;

  wire [127:0] lvl_pad;
  wire [106:0] rise_now;
  wire [106:0] fall_now;
  wire [18:0] edge_rise;
  wire [18:0] edge_fall;
  wire [18:0] evt;
  wire [31:0] trig_wdata;

  // Loop indices, one per process so that no variable has two drivers.
  integer dp;
  integer wp;
  integer rp;

  // Cycles since reset; edges count only once the history stage holds a pin sample.
  reg [1:0] settle_q;
  reg [1:0] settle_d;

  // Decoded register hits, one bit per bank pair.
  reg [3:0] dir_hit;
  reg [3:0] out_hit;
  reg [3:0] set_hit;
  reg [3:0] clr_hit;
  reg [3:0] in_hit;
  wire settled;

  // Inputs cross into the clock domain before any logic sees them.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= 107'h0;
      sync2_q <= 107'h0;
      hist_q <= 107'h0;
    end else begin
      sync1_q <= {rtc_domain_io_pins, pin_in};
      sync2_q <= sync1_q;
      hist_q <= sync2_q;
    end
  end

  // Right after reset the history stage still holds its reset zero, so a pin
  // that idles high would look like a rising edge; events wait until it settles.
  always @* begin
    settle_d = settle_q;
    if (settle_q != `BGPIO_SETTLE_CNT) begin
      settle_d = settle_q + 2'h1;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_q <= `BGPIO_RST_SETTLE;
    end else begin
      settle_q <= settle_d;
    end
  end

  assign settled = (settle_q == `BGPIO_SETTLE_CNT);

  // Address decode of the bank pair registers, shared by writes and reads.
  always @* begin
    dir_hit = 4'h0;
    out_hit = 4'h0;
    set_hit = 4'h0;
    clr_hit = 4'h0;
    in_hit = 4'h0;
    for (dp = 0; dp < 4; dp = dp + 1) begin
      dir_hit[dp] = pair_hit(reg_addr, dp[1:0], `BGPIO_SUB_DIR);
      out_hit[dp] = pair_hit(reg_addr, dp[1:0], `BGPIO_SUB_OUT);
      set_hit[dp] = pair_hit(reg_addr, dp[1:0], `BGPIO_SUB_SET);
      clr_hit[dp] = pair_hit(reg_addr, dp[1:0], `BGPIO_SUB_CLR);
      in_hit[dp] = pair_hit(reg_addr, dp[1:0], `BGPIO_SUB_IN);
    end
  end

  assign lvl_pad = {21'h0, sync2_q};

  // Single-cycle edge strobes from the synchronised level and its history.
  assign rise_now = sync2_q & ~hist_q;
  assign fall_now = ~sync2_q & hist_q;

  assign edge_rise = {rise_now[106:104], 1'b0, rise_now[14:0]};
  assign edge_fall = {fall_now[106:104], 1'b0, fall_now[14:0]};

  // A pin fires on whichever of its edge kinds are selected, once settled.
  assign evt = ((edge_rise & rise_trig_q) | (edge_fall & fall_trig_q)) &
    {19{settled}};

  assign trig_wdata = reg_wdata & `BGPIO_TRIG_MASK;

  // Trigger selection and bank interrupt enable registers.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rise_trig_q <= `BGPIO_RST_TRIG;
      fall_trig_q <= `BGPIO_RST_TRIG;
      bank_en_q <= `BGPIO_RST_BANK_EN;
    end else if (reg_wr) begin
      case (reg_addr)
        `BGPIO_OFS_BANK_IRQ_ENABLE: begin
          bank_en_q <= reg_wdata[6:0];
        end
        `BGPIO_OFS_RISE_TRIGGER_SET: begin
          rise_trig_q <= rise_trig_q | trig_wdata[18:0];
        end
        `BGPIO_OFS_RISE_TRIGGER_CLEAR: begin
          rise_trig_q <= rise_trig_q & ~trig_wdata[18:0];
        end
        `BGPIO_OFS_FALL_TRIGGER_SET: begin
          fall_trig_q <= fall_trig_q | trig_wdata[18:0];
        end
        `BGPIO_OFS_FALL_TRIGGER_CLEAR: begin
          fall_trig_q <= fall_trig_q & ~trig_wdata[18:0];
        end
        default: begin
          bank_en_q <= bank_en_q;
        end
      endcase
    end
  end

  // Direction and output data registers of every bank pair.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oe_q <= `BGPIO_RST_OE;
      out_q <= `BGPIO_RST_OUT;
    end else if (reg_wr) begin
      for (wp = 0; wp < 4; wp = wp + 1) begin
        if (dir_hit[wp]) begin
          // A one in the direction register makes the pin an input.
          oe_q[wp*32 +: 32] <= ~reg_wdata & pair_mask(wp[1:0]);
        end else if (out_hit[wp]) begin
          out_q[wp*32 +: 32] <= reg_wdata & pair_mask(wp[1:0]);
        end else if (set_hit[wp]) begin
          out_q[wp*32 +: 32] <= out_q[wp*32 +: 32] |
            (reg_wdata & pair_mask(wp[1:0]));
        end else if (clr_hit[wp]) begin
          out_q[wp*32 +: 32] <= out_q[wp*32 +: 32] &
            ~(reg_wdata & pair_mask(wp[1:0]));
        end
      end
    end
  end

  // Read data mux; unmapped offsets return zero.
  always @* begin
    rdata_d = `BGPIO_RST_RDATA;
    case (reg_addr)
      `BGPIO_OFS_IDENT: begin
        rdata_d = IDENT_VALUE;
      end
      `BGPIO_OFS_BANK_IRQ_ENABLE: begin
        rdata_d = {25'd0, bank_en_q};
      end
      `BGPIO_OFS_RISE_TRIGGER_SET, `BGPIO_OFS_RISE_TRIGGER_CLEAR: begin
        rdata_d = {13'd0, rise_trig_q};
      end
      `BGPIO_OFS_FALL_TRIGGER_SET, `BGPIO_OFS_FALL_TRIGGER_CLEAR: begin
        rdata_d = {13'd0, fall_trig_q};
      end
      default: begin
        rdata_d = `BGPIO_RST_RDATA;
      end
    endcase
    for (rp = 0; rp < 4; rp = rp + 1) begin
      if (dir_hit[rp]) begin
        rdata_d = ~oe_q[rp*32 +: 32] & pair_mask(rp[1:0]);
      end else if (out_hit[rp] || set_hit[rp] || clr_hit[rp]) begin
        rdata_d = out_q[rp*32 +: 32];
      end else if (in_hit[rp]) begin
        // Real pin levels, so driven pins read back what the wire carries.
        rdata_d = lvl_pad[rp*32 +: 32] & pair_in_mask(rp[1:0]);
      end
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= `BGPIO_RST_RDATA;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= `BGPIO_RST_RDATA;
    end
  end

  // Interrupt and DMA event pulses, one clock wide per qualifying edge.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_q <= 15'd0;
      rtc_irq_q <= 3'd0;
      dma_q <= 15'd0;
    end else begin
      irq_q <= evt[14:0] & {15{bank_en_q[`BGPIO_BANK0_EN_BIT]}};
      rtc_irq_q <= evt[18:16] & {3{bank_en_q[`BGPIO_BANK6_EN_BIT]}};
      dma_q <= evt[14:0];
    end
  end

  assign reg_rdata = rdata_q;
  // The RTC pins have no output path here; only pins 0 to 103 drive.
  assign pin_out = out_q[103:0];
  assign pin_oe = oe_q[103:0];
  assign bank0_irq = irq_q;
  assign rtc_irq = rtc_irq_q;
  assign bank0_dma_evt = dma_q;

endmodule

// file: dv/bgpio_ext_dev.sv
// Model of the external devices wired to the general-purpose pins.
`timescale 1ns/1ns
module bgpio_ext_dev (
  input wire [103:0] pin_out,
  input wire [103:0] pin_oe,
  input wire [103:0] ext_lvl,
  output wire [103:0] pin_in
);
  // A driven pin carries the block's level, an undriven one the device's level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// file: dv/bgpio_chk.sv
// Assertion checker for the banked pin block, bound to its top module.
`timescale 1ns/1ns
module bgpio_chk (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [103:0] pin_in,
  input wire [103:0] pin_out,
  input wire [103:0] pin_oe,
  input wire [2:0] rtc_domain_io_pins,
  input wire [14:0] bank0_irq,
  input wire [2:0] rtc_irq,
  input wire [14:0] bank0_dma_evt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  dir_oe_a: assert property (wr_at(8'h10) |=> pin_oe[31:0] == ~$past(reg_wdata))
    else $error("enable does not follow direction write");
  out_write_a: assert property (wr_at(8'h14) |=> pin_out[31:0] == $past(reg_wdata))
    else $error("direct output write not applied");
  set_write_a: assert property (wr_at(8'h18) |=>
    pin_out[31:0] == ($past(pin_out[31:0]) | $past(reg_wdata)))
    else $error("set write wrong");
  clr_write_a: assert property (wr_at(8'h1C) |=>
    pin_out[31:0] == ($past(pin_out[31:0]) & ~$past(reg_wdata)))
    else $error("clear write wrong");
  in_read_a: assert property (rd_at(8'h20) |=> reg_rdata == $past(pin_in[31:0], 3))
    else $error("input read wrong");
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  single_pulse_a: assert property (|bank0_irq |=> (bank0_irq & $past(bank0_irq)) == 15'h0)
    else $error("interrupt pulse too long");
  dma_edge_a: assert property (bank0_dma_evt[0] |->
    $past(pin_in[0], 3) != $past(pin_in[0], 4))
    else $error("event without pin edge");
  rtc_edge_a: assert property (rtc_irq[0] |->
    $past(rtc_domain_io_pins[0], 3) != $past(rtc_domain_io_pins[0], 4))
    else $error("rtc interrupt without edge");
endmodule
bind bgpio_top bgpio_chk chk_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .rtc_domain_io_pins(rtc_domain_io_pins), .bank0_irq(bank0_irq), .rtc_irq(rtc_irq),
  .bank0_dma_evt(bank0_dma_evt));

// file: dv/tb.sv
// Self-checking testbench of the banked pin block.
`timescale 1ns/1ns
module tb;
  logic clk_sys, rst, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [103:0] pin_in, pin_out, pin_oe, ext_lvl;
  logic [2:0] rtc_pins, rtc_irq;
  logic [14:0] bank0_irq, bank0_dma_evt;
  int fails = 0, total_checks = 0, n_irq = 0, n_dma = 0, n_rtc = 0;
  logic [7:0] bases [3] = '{8'h38, 8'h60, 8'h88};
  logic [31:0] masks [3] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_00FF};
  bgpio_top dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .rtc_domain_io_pins(rtc_pins),
    .bank0_irq(bank0_irq), .rtc_irq(rtc_irq), .bank0_dma_evt(bank0_dma_evt));
  bgpio_ext_dev ext_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_irq <= n_irq + bank0_irq[0];
    n_dma <= n_dma + bank0_dma_evt[0];
    n_rtc <= n_rtc + rtc_irq[0];
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask
  // Moves pin 0 and rtc pin 0, then counts the pulses that follow.
  task automatic edge_run(input logic lv, input logic rl, input int ei, ed, er);
    int i0, d0, r0;
    i0 = n_irq;
    d0 = n_dma;
    r0 = n_rtc;
    @(posedge clk_sys);
    ext_lvl[0] <= lv;
    rtc_pins[0] <= rl;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(n_irq - i0, ei, "bank0 irq count");
    chk(n_dma - d0, ed, "dma count");
    chk(n_rtc - r0, er, "rtc irq count");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    ext_lvl = {72'h0, 16'h5A5A, 16'h0000};
    rtc_pins = 3'b110;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(8'h10, 32'hFFFF_FFFF, "dir01");
    rdc(8'h14, 32'h0000_0000, "out01");
    rdc(8'h2C, 32'h0000_0000, "fall trig");
    chk(pin_oe[31:0], 32'h0000_0000, "oe01");
    $display("test reset done");
    wr(8'h10, 32'hFFFF_0000);
    wr(8'h14, 32'h0000_A5A5);
    wr(8'h18, 32'h0000_0102);
    wr(8'h1C, 32'h0000_0005);
    rdc(8'h18, 32'h0000_A5A2, "out01");
    chk(pin_oe[31:0], 32'h0000_FFFF, "oe01");
    chk(pin_out[31:0], 32'h0000_A5A2, "pins01");
    rdc(8'h20, 32'h5A5A_A5A2, "in01");
    $display("test outputs done");
    foreach (bases[k]) begin
      wr(bases[k] + 8'h04, 32'hFFFF_FFFF);
      rdc(bases[k] + 8'h04, masks[k], "out pair");
    end
    wr(8'h88, 32'h0000_0000);
    // The new drive must pass the two input flip-flops before it can be read.
    repeat (2) @(posedge clk_sys);
    rdc(8'h98, 32'h0000_06FF, "in6");
    wr(8'h04, 32'hFFFF_FFFF);
    rdc(8'h04, 32'h0000_0000, "unmapped");
    $display("test banks done");
    wr(8'h10, 32'hFFFF_FFFF);
    wr(8'h08, 32'h0000_0041);
    wr(8'h24, 32'h0001_0001);
    rdc(8'h28, 32'h0001_0001, "rise trig");
    edge_run(1'b1, 1'b1, 1, 1, 1);
    edge_run(1'b0, 1'b0, 0, 0, 0);
    wr(8'h2C, 32'h0000_0001);
    wr(8'h28, 32'h0000_0001);
    rdc(8'h24, 32'h0001_0000, "rise trig");
    edge_run(1'b1, 1'b1, 0, 0, 1);
    edge_run(1'b0, 1'b0, 1, 1, 0);
    wr(8'h08, 32'h0000_0000);
    edge_run(1'b1, 1'b1, 0, 0, 0);
    edge_run(1'b0, 1'b0, 0, 1, 0);
    wr(8'h24, 32'hFFFF_FFFF);
    rdc(8'h24, 32'h0007_7FFF, "rise trig");
    $display("test events done");
    // A pin held high through a reset must not look like a rising edge after it.
    rst <= 1'b1;
    ext_lvl[0] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wr(8'h24, 32'h0000_0001);
    edge_run(1'b1, 1'b1, 0, 0, 0);
    rdc(8'h08, 32'h0000_0000, "bank enable");
    $display("test reset again done");
    report_and_stop();
  end
endmodule
